// >>> logic/adsc_core.sv
// Purpose: Converter control core: command decode, DAC buffer power, scan sequencing, FIFO.
// Assumes: core_clk stands in for the internal oscillator; analog codes are steady on it.
// Notes: The serial front end runs on sclk; commands and byte claims cross by toggles and syncs, read bytes as held data.
// Behaviour
// - Power-up pattern 001 connects and activates each selected DAC buffer.
// - Pattern 010 disconnects selected DAC outputs to high impedance.
// - Pattern 100 pulls selected outputs to ground via 1k; 000 via 100k.
// - Pattern 111 pulls selected outputs to the first reference via 100k.
// - Results leave as two bytes, MSB first, four zero bits ahead.
// - Serial output changes on falling serial clock edges.
// - Unipolar straight binary; bipolar and temperature in two's complement.
// - One LSB is reference over 4096; temperature LSB is 0.125 degC.
// - A cut-short first byte loses its remaining bits; next read moves on.
// - A cut-short second byte is dropped; later entries stay readable.
// - A write cut short before its last bit is ignored entirely.
// - Mode 00 start wakes, converts channels 0 to the last requested one, stores, shuts down, flags.
// - End-of-conversion flag stays low until chip select or start falls.
// - A requested temperature result goes into the FIFO first.
// - Power and setup writes are accepted during conversion without aborting it; a conversion byte is dropped.
// - Clock mode resets to 10, where a conversion byte starts a scan.
// - Two-bit clock mode field; 11 means externally clocked conversion.
`timescale 1ns/1ps
module adsc_core
  import adsc_pkg::*;
#(
  parameter int N_CH = 8,
  parameter int TEMP_CYCLES = TEMP_CYC
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  output logic dout,
  input wire logic conversion_start_n,
  input wire logic [RESULT_W-1:0] adc_code,
  input wire logic [RESULT_W-1:0] temp_code,
  input wire logic bipolar_mode,
  output logic eoc_n,
  output logic adc_awake,
  output logic adc_sample,
  output logic [2:0] adc_channel,
  output logic adc_temp_sel,
  output logic ext_clocked,
  output logic [1:0] clock_mode,
  output adsc_dac_t [N_DAC-1:0] dac_state
);

  // ----------------------------------------------------------------
  // Serial front end on the link clock
  // ----------------------------------------------------------------
  adsc_cmd_t link_cmd;
  logic link_take;
  logic [BYTE_W-1:0] rd_byte_ff;

  adsc_link u_link (
    .rstn(rstn),
    .sclk(sclk),
    .cs_n(cs_n),
    .din(din),
    .rd_byte(rd_byte_ff),
    .dout(dout),
    .cmd(link_cmd),
    .take_tgl(link_take)
  );

  // ----------------------------------------------------------------
  // Synchronisers into core_clk
  // ----------------------------------------------------------------
  // Bit 0 chip select, 1 start strobe, 2 command toggle, 3 byte-take toggle
  logic [3:0] async_in;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;

  assign async_in = {link_take, link_cmd.tgl, conversion_start_n, cs_n};

  // The first stage feeds only the second; edges are found between stages two and three
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_ff <= 4'h3;
      sync2_ff <= 4'h3;
      sync3_ff <= 4'h3;
    end
    else
    begin
      sync1_ff <= async_in;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic cs_fall;
  logic start_fall;
  logic start_rise;
  logic cmd_evt;
  logic take_evt;

  assign cs_fall = sync3_ff[0] & ~sync2_ff[0];
  assign start_fall = sync3_ff[1] & ~sync2_ff[1];
  assign start_rise = ~sync3_ff[1] & sync2_ff[1];
  assign cmd_evt = sync3_ff[2] ^ sync2_ff[2];
  assign take_evt = sync3_ff[3] ^ sync2_ff[3];

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // The word is written on the same sclk edge as its toggle, and is steady here once the toggle is through the syncs
  logic [WORD_W-1:0] cmd_word;
  logic [3:0] cmd_op;
  logic is_power;
  logic is_conv;
  logic is_setup;
  logic [N_DAC-1:0] power_sel;
  logic [2:0] power_field;

  assign cmd_word = link_cmd.word;
  assign cmd_op = cmd_word[OP_LSB +: 4];
  assign is_power = cmd_evt && (cmd_op == CMD_POWER);
  assign is_conv = cmd_evt && (cmd_op == CMD_CONV);
  assign is_setup = cmd_evt && (cmd_op == CMD_SETUP);
  // Only DAC_SELECT_BIT_ZERO..DAC_SELECT_BIT_THREE select bits are looked at; the upper four are don't-care
  assign power_sel = cmd_word[POWER_SEL_LSB +: N_DAC];
  assign power_field = cmd_word[PF_LSB +: 3];

  // ----------------------------------------------------------------
  // Clock mode
  // ----------------------------------------------------------------
  logic [1:0] clock_mode_ff;
  logic ext_clocked_ff;

  // Mode field of the setup byte; serial-start mode out of reset
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clock_mode_ff <= CKM_RESET;
      ext_clocked_ff <= 1'b0;
    end
    else if (is_setup)
    begin
      clock_mode_ff <= cmd_word[SETUP_MODE_LSB +: 2];
      ext_clocked_ff <= (cmd_word[SETUP_MODE_LSB +: 2] == CKM_EXT);
    end
  end

  assign clock_mode = clock_mode_ff;
  assign ext_clocked = ext_clocked_ff;

  // ----------------------------------------------------------------
  // DAC buffer power states
  // ----------------------------------------------------------------
  adsc_dac_t [N_DAC-1:0] dac_ff;
  adsc_dac_t pwr_new;
  logic pwr_known;

  // Patterns outside the five listed leave every buffer as it is
  always_comb
  begin
    pwr_new = DAC_RST;
    pwr_known = 1'b1;
    case (power_field)
      PF_UP: pwr_new = '{active: 1'b1, pd: PD_HIZ};
      PF_HIZ: pwr_new = '{active: 1'b0, pd: PD_HIZ};
      PF_GND_1K: pwr_new = '{active: 1'b0, pd: PD_GND_1K};
      PF_GND_100K: pwr_new = '{active: 1'b0, pd: PD_GND_100K};
      PF_REF_100K: pwr_new = '{active: 1'b0, pd: PD_REF_100K};
      default: pwr_known = 1'b0;
    endcase
  end

  // Power commands act at once, even mid-scan, and touch selected buffers only
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      dac_ff <= {N_DAC{DAC_RST}};
    else if (is_power && pwr_known)
    begin
      for (int i = 0; i < N_DAC; i++)
      begin
        if (power_sel[i])
          dac_ff[i] <= pwr_new;
      end
    end
  end

  assign dac_state = dac_ff;

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_WAKE, S_TEMP, S_CONV, S_DOWN} adsc_state_t;

  adsc_state_t state_ff;
  adsc_state_t nxt_state;
  logic [15:0] timer_ff;
  logic [2:0] chan_ff;
  logic [2:0] last_ch_ff;
  logic temp_req_ff;
  logic trig_conversion_start_n;
  logic trig_serial;
  logic scan_go;
  logic timer_done;
  logic [15:0] step_len;
  logic push;
  logic [RESULT_W-1:0] push_data;
  logic [RESULT_W-1:0] adc_enc;

  // Mode 00 starts on the strobe's rising edge, mode 10 on a conversion byte;
  // a start while busy is dropped, protecting the FIFO against an early strobe
  assign trig_conversion_start_n = (clock_mode_ff == CKM_CONVERSION_START_N) && start_rise;
  assign trig_serial = (clock_mode_ff == CKM_SERIAL) && is_conv;
  assign scan_go = (state_ff == S_IDLE) && (trig_conversion_start_n || trig_serial);

  assign step_len = (state_ff == S_WAKE) ? 16'(WAKE_CYC) :
                    (state_ff == S_TEMP) ? 16'(TEMP_CYCLES) : 16'(CONV_CYC);
  assign timer_done = (timer_ff == step_len - 16'h0001);

  // Bipolar codes arrive offset-binary; flipping the MSB gives two's complement.
  // Scale is fixed by the analog core: LSB = reference / LSB_DIVISOR, 0.125 degC.
  assign adc_enc = bipolar_mode ? {~adc_code[RESULT_W-1], adc_code[RESULT_W-2:0]} :
                   adc_code;
  assign push = timer_done && ((state_ff == S_TEMP) || (state_ff == S_CONV));
  assign push_data = (state_ff == S_TEMP) ? temp_code : adc_enc;

  // Next state: wake, optional temperature first, channels, shut down
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE:
        if (scan_go)
          nxt_state = S_WAKE;
      S_WAKE:
        if (timer_done)
          nxt_state = temp_req_ff ? S_TEMP : S_CONV;
      S_TEMP:
        if (timer_done)
          nxt_state = S_CONV;
      S_CONV:
        if (timer_done && (chan_ff == last_ch_ff))
          nxt_state = S_DOWN;
      S_DOWN:
        nxt_state = S_IDLE;
      default:
        nxt_state = S_IDLE;
    endcase
  end

  // State, step timer and channel pointer
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= S_IDLE;
      timer_ff <= 16'h0000;
      chan_ff <= 3'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      timer_ff <= (timer_done || state_ff == S_IDLE) ? 16'h0000 : timer_ff + 16'h0001;
      if (scan_go)
        chan_ff <= 3'h0;
      else if (timer_done && state_ff == S_CONV)
        chan_ff <= chan_ff + 3'h1;
    end
  end

  // Scan request: mode 10 takes it from the conversion byte; mode 00 reuses the last one
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      temp_req_ff <= 1'b0;
      last_ch_ff <= 3'h0;
    end
    else if (is_conv && state_ff == S_IDLE)
    begin
      temp_req_ff <= cmd_word[CONV_TEMP_BIT];
      last_ch_ff <= (cmd_word[CONV_NCH_LSB +: 3] > 3'(N_CH - 1)) ?
                    3'(N_CH - 1) : cmd_word[CONV_NCH_LSB +: 3];
    end
  end

  // ----------------------------------------------------------------
  // Analog core controls
  // ----------------------------------------------------------------
  logic awake_ff;
  logic sample_ff;
  logic [2:0] adc_ch_ff;
  logic temp_sel_ff;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      awake_ff <= 1'b0;
      sample_ff <= 1'b0;
      adc_ch_ff <= 3'h0;
      temp_sel_ff <= 1'b0;
    end
    else
    begin
      awake_ff <= (nxt_state != S_IDLE) && (nxt_state != S_DOWN);
      sample_ff <= push;
      adc_ch_ff <= chan_ff;
      temp_sel_ff <= (nxt_state == S_TEMP);
    end
  end

  assign adc_awake = awake_ff;
  assign adc_sample = sample_ff;
  assign adc_channel = adc_ch_ff;
  assign adc_temp_sel = temp_sel_ff;

  // ----------------------------------------------------------------
  // End-of-conversion flag
  // ----------------------------------------------------------------
  logic eoc_n_ff;

  // Finishing a scan beats a release in the same cycle, so no completion is lost
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      eoc_n_ff <= 1'b1;
    else if (state_ff == S_DOWN)
      eoc_n_ff <= 1'b0;
    else if (cs_fall || start_fall)
      eoc_n_ff <= 1'b1;
  end

  assign eoc_n = eoc_n_ff;

  // ----------------------------------------------------------------
  // Result FIFO and byte readout
  // ----------------------------------------------------------------
  localparam int PTR_W = $clog2(FIFO_DEPTH);

  logic [RESULT_W-1:0] fifo_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_ff;
  logic [PTR_W-1:0] rd_ptr_ff;
  logic [PTR_W:0] count_ff;
  logic low_half_ff;
  logic do_push;
  logic do_pop;
  logic [RESULT_W-1:0] head;
  logic [BYTE_W-1:0] nxt_rd_byte;

  function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(FIFO_DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  // A new scan empties the FIFO; writes beyond depth are dropped
  assign do_push = push && (count_ff != (PTR_W+1)'(FIFO_DEPTH));
  assign do_pop = take_evt && low_half_ff && (count_ff != '0);
  assign head = fifo_mem[rd_ptr_ff];

  // Byte that the next serial byte slot will carry
  always_comb
  begin
    nxt_rd_byte = 8'h00;
    if (count_ff != '0)
      nxt_rd_byte = low_half_ff ? head[BYTE_W-1:0] : {4'h0, head[RESULT_W-1:BYTE_W]};
  end

  // Storage
  always_ff @(posedge core_clk)
  begin
    if (do_push)
      fifo_mem[wr_ptr_ff] <= push_data;
  end

  // Pointers: each byte claimed while the FIFO holds data advances the half; the second half pops the entry
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      low_half_ff <= 1'b0;
    end
    else if (scan_go)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      low_half_ff <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_ptr_ff <= ptr_inc(wr_ptr_ff);
      if (do_pop)
        rd_ptr_ff <= ptr_inc(rd_ptr_ff);
      count_ff <= count_ff + {{PTR_W{1'b0}}, do_push} - {{PTR_W{1'b0}}, do_pop};
      if (take_evt && count_ff != '0)
        low_half_ff <= ~low_half_ff;
    end
  end

  // Byte toward sclk side; registered from nxt_rd_byte on every core_clk
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rd_byte_ff <= 8'h00;
    else
      rd_byte_ff <= nxt_rd_byte;
  end

endmodule

// >>> logic/adsc_pkg.sv
// Purpose: Shared constants, types and helpers of the converter serial control block.
// Assumes: core_clk at 100 MHz; serial words arrive MSB first.
// Notes: Every number the two design files share lives here once.
package adsc_pkg;

  // ----------------------------------------------------------------
  // Clock rate and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int WAKE_NS = 1000;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_NS = 4000;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int TEMP_NS = 58100;
  localparam int TEMP_CYC = (TEMP_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int RESULT_W = 12;
  localparam int PAD_W = 4;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 17;
  localparam int N_DAC = 4;
  localparam int LSB_DIVISOR = 4096;

  // ----------------------------------------------------------------
  // Command codes and field positions of the serial word
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_POWER = 4'hF;
  localparam logic [3:0] CMD_CONV = 4'h1;
  localparam logic [3:0] CMD_SETUP = 4'h2;
  localparam int OP_LSB = 12;
  localparam int POWER_SEL_LSB = 4;
  localparam int PF_LSB = 1;
  localparam int CONV_TEMP_BIT = 11;
  localparam int CONV_NCH_LSB = 8;
  localparam int SETUP_MODE_LSB = 8;

  // Power field patterns
  localparam logic [2:0] PF_UP = 3'h1;
  localparam logic [2:0] PF_HIZ = 3'h2;
  localparam logic [2:0] PF_GND_1K = 3'h4;
  localparam logic [2:0] PF_GND_100K = 3'h0;
  localparam logic [2:0] PF_REF_100K = 3'h7;

  // Clock modes
  localparam logic [1:0] CKM_CONVERSION_START_N = 2'h0;
  localparam logic [1:0] CKM_SERIAL = 2'h2;
  localparam logic [1:0] CKM_EXT = 2'h3;
  localparam logic [1:0] CKM_RESET = CKM_SERIAL;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PD_HIZ, PD_GND_1K, PD_GND_100K, PD_REF_100K} adsc_pd_t;

  typedef struct packed {
    logic active;
    adsc_pd_t pd;
  } adsc_dac_t;

  typedef struct packed {
    logic tgl;
    logic [WORD_W-1:0] word;
  } adsc_cmd_t;

  localparam adsc_dac_t DAC_RST = '{active: 1'b0, pd: PD_GND_100K};

  // Commands that carry a second byte
  function automatic logic adsc_is_word(input logic [3:0] op);
    return op == CMD_POWER;
  endfunction

endpackage

// >>> logic/adsc_link.sv
// Purpose: Serial-clock side of the interface: shifts commands in, result bytes out.
// Assumes: Mode 0 framing; chip select low frames a transfer; sclk idles between frames.
// Notes: Frame state is cleared by chip select itself, since sclk stops outside frames.
`timescale 1ns/1ps
module adsc_link
  import adsc_pkg::*;
(
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic [BYTE_W-1:0] rd_byte,
  output logic dout,
  output adsc_cmd_t cmd,
  output logic take_tgl
);

  // ----------------------------------------------------------------
  // Receive side, rising edges
  // ----------------------------------------------------------------
  logic frame_rst_n;
  logic [4:0] rx_cnt_ff;
  logic [WORD_W-1:0] shift_ff;
  logic [WORD_W-1:0] nxt_shift;
  logic [4:0] nxt_rx_cnt;
  logic short_done;
  logic word_done;
  adsc_cmd_t cmd_ff;

  assign frame_rst_n = rstn & ~cs_n;
  assign nxt_shift = {shift_ff[WORD_W-2:0], din};
  assign nxt_rx_cnt = (rx_cnt_ff == 5'h10) ? rx_cnt_ff : rx_cnt_ff + 5'h01;
  // A command counts only once its last bit is in; a short frame leaves nothing behind
  assign short_done = (rx_cnt_ff == 5'h07) && !adsc_is_word(nxt_shift[7:4]);
  assign word_done = (rx_cnt_ff == 5'h0F) && adsc_is_word(shift_ff[14:11]);

  // Bit counter and shifter, cleared whenever the frame ends
  always_ff @(posedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      rx_cnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
    end
    else
    begin
      rx_cnt_ff <= nxt_rx_cnt;
      shift_ff <= nxt_shift;
    end
  end

  // Completed command: word is held until the next one, toggle marks it
  always_ff @(posedge sclk or negedge rstn)
  begin
    if (!rstn)
      cmd_ff <= '0;
    else if (short_done)
      cmd_ff <= '{tgl: ~cmd_ff.tgl, word: {nxt_shift[7:0], 8'h00}};
    else if (word_done)
      cmd_ff <= '{tgl: ~cmd_ff.tgl, word: nxt_shift};
  end

  assign cmd = cmd_ff;

  // ----------------------------------------------------------------
  // Transmit side, falling edges
  // ----------------------------------------------------------------
  logic [2:0] tx_cnt_ff;
  logic [BYTE_W-1:0] tx_byte_ff;
  logic dout_ff;
  logic take_ff;
  logic byte_start;

  assign byte_start = (tx_cnt_ff == 3'h0);

  // Output changes on falling sclk within a frame and clears when cs_n rises; rd_byte is held steady by the core while read
  always_ff @(negedge sclk or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      tx_cnt_ff <= 3'h0;
      tx_byte_ff <= 8'h00;
      dout_ff <= 1'b0;
    end
    else if (byte_start)
    begin
      tx_cnt_ff <= tx_cnt_ff + 3'h1;
      tx_byte_ff <= {rd_byte[BYTE_W-2:0], 1'b0};
      dout_ff <= rd_byte[BYTE_W-1];
    end
    else
    begin
      tx_cnt_ff <= tx_cnt_ff + 3'h1;
      tx_byte_ff <= {tx_byte_ff[BYTE_W-2:0], 1'b0};
      dout_ff <= tx_byte_ff[BYTE_W-1];
    end
  end

  // Byte is claimed as it starts, so a cut-short byte is simply gone
  always_ff @(negedge sclk or negedge rstn)
  begin
    if (!rstn)
      take_ff <= 1'b0;
    else if (byte_start && !cs_n)
      take_ff <= ~take_ff;
  end

  assign dout = dout_ff;
  assign take_tgl = take_ff;

endmodule

// >>> tb/adsc_core_chk.sv
// Purpose: Port-level timing checks on the converter control core.
// Assumes: One core_clk domain; link signals are watched as data.
// Notes: Bound to every adsc_core instance.
`timescale 1ns/1ps
module adsc_core_chk
  import adsc_pkg::*;
#(
  parameter int N_CH = 8,
  parameter int TEMP_CYCLES = TEMP_CYC
)
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic conversion_start_n,
  input wire logic dout,
  input wire logic eoc_n,
  input wire logic adc_awake,
  input wire logic adc_sample,
  input wire logic adc_temp_sel,
  input wire logic [2:0] adc_channel,
  input wire logic ext_clocked,
  input wire logic [1:0] clock_mode,
  input wire adsc_dac_t [N_DAC-1:0] dac_state
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  reset_mode_a: assert property ($rose(rstn) |-> clock_mode == CKM_RESET)
    else $error("clock mode wrong after reset");
  ext_mode_a: assert property ((clock_mode == CKM_EXT)[*3] |-> ext_clocked)
    else $error("external clocking flag missing");
  // Six quiet cycles give the synchronisers time to forget an old fall
  eoc_hold_a: assert property ((cs_n && conversion_start_n)[*6] ##0 !eoc_n |=> !eoc_n)
    else $error("end of conversion released without cause");
  eoc_release_a: assert property ($fell(cs_n) && !eoc_n |-> ##[1:6] eoc_n)
    else $error("end of conversion not released by chip select");
  eoc_done_a: assert property ($fell(eoc_n) |-> !adc_awake)
    else $error("end of conversion while converter awake");
  eoc_after_a: assert property ($fell(adc_awake) |-> ##[0:4] !eoc_n)
    else $error("no end of conversion after shutdown");
  sample_awake_a: assert property (adc_sample |-> $past(adc_awake))
    else $error("result stored while asleep");
  dout_fall_a: assert property ($changed(dout) && !cs_n |-> !sclk)
    else $error("serial output moved off a falling edge");
  dac_quiet_a: assert property (cs_n[*8] |=> $stable(dac_state))
    else $error("buffer state changed without a frame");
  temp_first_a: assert property (adc_temp_sel |-> adc_awake && adc_channel == 3'h0)
    else $error("temperature step not at the head of a scan");
endmodule

bind adsc_core adsc_core_chk #(.N_CH(N_CH), .TEMP_CYCLES(TEMP_CYCLES)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .dout(dout),
  .conversion_start_n(conversion_start_n), .eoc_n(eoc_n), .adc_awake(adc_awake),
  .adc_sample(adc_sample), .ext_clocked(ext_clocked), .clock_mode(clock_mode),
  .adc_temp_sel(adc_temp_sel), .adc_channel(adc_channel),
  .dac_state(dac_state)
);

// >>> tb/adsc_host.sv
// Purpose: Host model driving the serial frame and the start strobe.
// Assumes: Mode 0 framing, sclk period 160 ns, idle low between frames.
// Notes: Callers wait for end of conversion before reading.
`timescale 1ns/1ps
module adsc_host
(
  output logic sclk,
  output logic cs_n,
  output logic din,
  output logic conversion_start_n,
  input wire logic dout
);
  // Idle levels
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
    conversion_start_n = 1'b1;
  end

  // One frame of n clocks; samples dout on each rising edge after the first
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] r);
    r = '0;
    #3 cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      #1 din = w[31-i];
      #79 sclk = 1'b1;
      if (i > 0)
        r = {r[30:0], dout};
      // Frame ends with sclk high: a last fall with cs_n low would claim a byte
      if (i == n - 1)
        #40 cs_n = 1'b1;
      #80 sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    din = ~din; // Released line must not look driven
  endtask

  // Strobe low 50 ns, starting 2 ns after the call
  task automatic start_pulse();
    #2 conversion_start_n = 1'b0;
    #50 conversion_start_n = 1'b1;
  endtask
endmodule

// >>> tb/tb_adsc_core.sv
// Purpose: Self-checking bench of the converter control core.
// Assumes: Host model on the serial side; codes held steady per scan.
// Notes: Temperature step shortened so a command fits before the first store.
`timescale 1ns/1ps
module tb_adsc_core;
  import adsc_pkg::*;
  localparam int TCYC = 400;
  logic core_clk, rstn, sclk, cs_n, din, dout, conversion_start_n, bipolar_mode;
  logic eoc_n, adc_awake, adc_sample, ext_clocked;
  logic [RESULT_W-1:0] adc_code, temp_code;
  logic [1:0] clock_mode;
  logic [31:0] rd;
  logic [2:0] pats [6] = '{PF_UP, PF_HIZ, PF_GND_1K, PF_GND_100K, PF_REF_100K, 3'h3};
  logic [15:0] q [$];
  adsc_dac_t [N_DAC-1:0] dac_state, exp_dac;
  int err_total, checks;

  adsc_core #(.N_CH(8), .TEMP_CYCLES(TCYC)) DUT (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .conversion_start_n(conversion_start_n), .adc_code(adc_code), .temp_code(temp_code),
    .bipolar_mode(bipolar_mode), .eoc_n(eoc_n), .adc_awake(adc_awake),
    .adc_sample(adc_sample), .adc_channel(), .adc_temp_sel(), .ext_clocked(ext_clocked),
    .clock_mode(clock_mode), .dac_state(dac_state)
  );
  adsc_host host (.sclk(sclk), .cs_n(cs_n), .din(din),
    .conversion_start_n(conversion_start_n), .dout(dout));

  // Core clock, 100 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait for the end-of-conversion flag
  task automatic wait_eoc();
    int n;
    n = 0;
    while (eoc_n !== 1'b0 && n < 4000)
    begin
      @(posedge core_clk);
      n++;
    end
    check("eoc_n", 32'(eoc_n), 32'h0);
  endtask

  // Power command with the reference model of the buffer states
  task automatic dac_cmd(input logic [3:0] op, input logic [3:0] sel, input logic [2:0] pf,
    input int n);
    host.xfer({op, 4'($urandom), sel, pf, 1'b1, 16'h0}, n, rd);
    repeat (6) @(posedge core_clk);
    if (op == 4'hF && n == 16)
      for (int i = 0; i < N_DAC; i++)
        if (sel[i])
          case (pf)
            PF_UP: exp_dac[i] = '{1'b1, PD_HIZ};
            PF_HIZ: exp_dac[i] = '{1'b0, PD_HIZ};
            PF_GND_1K: exp_dac[i] = '{1'b0, PD_GND_1K};
            PF_GND_100K: exp_dac[i] = '{1'b0, PD_GND_100K};
            PF_REF_100K: exp_dac[i] = '{1'b0, PD_REF_100K};
            default: ;
          endcase
    check("dac_state", 32'(dac_state), 32'(exp_dac));
  endtask

  // New random codes and the expected FIFO contents, temperature first
  task automatic new_codes();
    @(posedge core_clk);
    adc_code <= 12'($urandom);
    temp_code <= 12'($urandom);
    bipolar_mode <= 1'($urandom);
    @(posedge core_clk);
    q.push_back({4'h0, temp_code});
    repeat (4) q.push_back({4'h0, adc_code ^ {bipolar_mode, 11'h0}});
  endtask

  // Full, partial first byte, partial second byte, then two full entries
  task automatic read_scan();
    logic [15:0] e;
    e = q.pop_front();
    host.xfer(32'h0, 17, rd);
    check("temp", 32'(rd[15:0]), 32'(e));
    e = q.pop_front();
    host.xfer(32'h0, 7, rd);
    check("hi_part", 32'(rd[5:0]), 32'(e[15:10]));
    host.xfer(32'h0, 9, rd);
    check("lo_next", 32'(rd[7:0]), 32'(e[7:0]));
    e = q.pop_front();
    host.xfer(32'h0, 13, rd);
    check("lo_part", 32'(rd[11:0]), 32'(e[15:4]));
    repeat (2)
    begin
      host.xfer(32'h0, 17, rd);
      check("entry", 32'(rd[15:0]), 32'(q.pop_front()));
    end
  endtask

  // Watchdog, well past the expected run of about 15k cycles
  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_total++;
    conclude();
  end

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    adc_code = '0;
    temp_code = '0;
    bipolar_mode = 1'b0;
    err_total = 0;
    checks = 0;
    void'($urandom(32'hB4BDE25B));
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < N_DAC; i++)
      exp_dac[i] = DAC_RST;
    check("mode", 32'(clock_mode), 32'(CKM_RESET));
    check("dac_rst", 32'(dac_state), 32'(exp_dac));
    for (int k = 0; k < 12; k++)
      dac_cmd(CMD_POWER, 4'($urandom), pats[k % 6], 16);
    dac_cmd(4'hE, 4'hF, PF_HIZ, 16);
    dac_cmd(CMD_POWER, 4'hF, PF_HIZ, 12);
    new_codes();
    host.xfer({CMD_CONV, 4'hB, 24'h0}, 8, rd);
    wait_eoc();
    read_scan();
    host.xfer({CMD_SETUP, 4'h0, 24'h0}, 8, rd);
    repeat (6) @(posedge core_clk);
    check("mode00", 32'(clock_mode), 32'(CKM_CONVERSION_START_N));
    new_codes();
    host.start_pulse();
    dac_cmd(CMD_POWER, 4'hF, PF_UP, 16);
    wait_eoc();
    read_scan();
    host.start_pulse();
    wait_eoc();
    host.start_pulse();
    repeat (8) @(posedge core_clk);
    check("eoc_rel", 32'(eoc_n), 32'h1);
    wait_eoc();
    host.xfer({CMD_SETUP, 4'h3, 24'h0}, 8, rd);
    repeat (6) @(posedge core_clk);
    check("ext", 32'({clock_mode, ext_clocked}), 32'h7);
    conclude();
  end
endmodule
